// File: hdl/itb_top.v
`timescale 1ns/100ps
`default_nettype none
`include "itb_regs.vh"

module itb_top
(
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        ir_sense_active,
   input  wire        ir_detect,
   input  wire        conv_done,
   input  wire        low_supply,
   input  wire        nv_write_end,
   input  wire [3:0]  tmr_match,
   input  wire        sub_clk_pin,
   input  wire        stack_full,
   input  wire        vec_ack,
   input  wire        irq_return_instr,
   output reg         vec_req_q,
   output reg  [2:0]  vec_id_q,
   output reg         wake_q
);

   // Software-visible state
   reg         global_irq_en_q;
   reg  [6:0]  src_en_q;
   reg  [6:0]  src_flag_q;
   reg  [3:0]  tmr_flag_q;
   reg  [3:0]  tmr_en_q;
   reg  [1:0]  tick_flag_q;
   reg  [1:0]  tick_en_q;
   reg  [7:0]  tbase_ctrl_q;

   // Bus slave state
   reg         aw_have_q;
   reg         w_have_q;
   reg  [7:0]  awaddr_q;
   reg  [31:0] wdata_q;
   reg  [3:0]  wstrb_q;

   reg         global_irq_en_d;
   reg  [6:0]  src_flag_d;
   reg  [3:0]  tmr_flag_d;
   reg  [1:0]  tick_flag_d;
   reg  [31:0] rd_word;
   reg         rd_hit;

   wire        do_write;
   wire        sub_rise;
   wire        tick0;
   wire        tick1;
   wire [6:0]  src_set;
   wire [6:0]  svc_clr;
   wire [6:0]  pending;
   wire [3:0]  tmr_rise;
   wire [1:0]  tick_rise;
   wire [31:0] wmask;
   wire [31:0] flag_mrg;
   wire [31:0] tmr_mrg;
   wire [31:0] tick_mrg;
   wire        wr_ctrl;
   wire        wr_en;
   wire        wr_flag;
   wire        wr_tmr;
   wire        wr_tick;
   wire        wr_tbase;
   wire        vec_go;

   // Byte-lane mask from write strobes
   function [31:0] strb_mask;
      input [3:0] s;
      begin
         strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      end
   endfunction

   // Lowest set bit wins: fixed priority, IR sensing highest
   function [2:0] prio_id;
      input [6:0] p;
      integer i;
      begin
         prio_id = 3'h0;
         for (i = 6; i >= 0; i = i - 1)
            if (p[i])
               prio_id = i[2:0];
      end
   endfunction

   // One-hot of a source index
   function [6:0] onehot7;
      input [2:0] id;
      begin
         onehot7 = 7'h01 << id;
      end
   endfunction

   // Merge a register field under the byte mask
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [31:0] m;
      begin
         merge = (old & ~m) | (nw & m);
      end
   endfunction

   // Sub clock arrives from a pin: synchronise before use
   itb_sync_rise u_sub_sync
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_in  (sub_clk_pin),
      .rise_q  (sub_rise)
   );

   itb_tick_gen u_tick
   (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .sub_rise   (sub_rise),
      .tbase_ctrl (tbase_ctrl_q),
      .tick0_q    (tick0),
      .tick1_q    (tick1)
   );

   // Write decode; both halves of a write must be held
   assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
   assign wmask    = strb_mask(wstrb_q);
   assign flag_mrg = merge({25'h0, src_flag_q}, wdata_q, wmask);
   assign tmr_mrg  = merge({28'h0, tmr_flag_q}, wdata_q, wmask);
   assign tick_mrg = merge({30'h0, tick_flag_q}, wdata_q, wmask);
   assign wr_ctrl  = do_write & (awaddr_q == `ITB_ADDR_CTRL);
   assign wr_en    = do_write & (awaddr_q == `ITB_ADDR_IRQ_EN);
   assign wr_flag  = do_write & (awaddr_q == `ITB_ADDR_IRQ_FLAG);
   assign wr_tmr   = do_write & (awaddr_q == `ITB_ADDR_TMR);
   assign wr_tick  = do_write & (awaddr_q == `ITB_ADDR_TICK);
   assign wr_tbase = do_write & (awaddr_q == `ITB_ADDR_TBASE);

   // Member flag rises gated by member enables feed the groups
   assign tmr_rise  = tmr_flag_d & ~tmr_flag_q & tmr_en_q;
   assign tick_rise = tick_flag_d & ~tick_flag_q & tick_en_q;

   // Hardware set events for the vectored flags
   assign src_set[`ITB_SRC_IR]   = ir_detect & ir_sense_active;
   assign src_set[`ITB_SRC_CONV] = conv_done;
   assign src_set[`ITB_SRC_LOWV] = low_supply;
   assign src_set[`ITB_SRC_NVW]  = nv_write_end;
   assign src_set[`ITB_SRC_GRP0] = |tmr_rise[1:0];
   assign src_set[`ITB_SRC_GRP1] = |tmr_rise[3:2];
   assign src_set[`ITB_SRC_GRP4] = |tick_rise;

   // Service clears only the vectored flag, never member flags
   assign vec_go  = vec_req_q & vec_ack;
   assign svc_clr = vec_go ? onehot7(vec_id_q) : 7'h00;
   assign pending = src_flag_q & src_en_q;

   // Flag next state: hardware set wins over any clear
   always @*
   begin
      src_flag_d  = src_flag_q;
      tmr_flag_d  = tmr_flag_q;
      tick_flag_d = tick_flag_q;
      if (wr_flag)
         src_flag_d = flag_mrg[6:0];
      if (wr_tmr)
         tmr_flag_d = tmr_mrg[3:0];
      if (wr_tick)
         tick_flag_d = tick_mrg[1:0];
      src_flag_d  = (src_flag_d & ~svc_clr) | src_set;
      tmr_flag_d  = tmr_flag_d | tmr_match;
      tick_flag_d = tick_flag_d | {tick1, tick0};
   end

   // Global enable: service clears, interrupt return sets
   always @*
   begin
      global_irq_en_d = global_irq_en_q;
      if (wr_ctrl & wstrb_q[0])
         global_irq_en_d = wdata_q[`ITB_CTRL_GIE];
      if (irq_return_instr)
         global_irq_en_d = 1'b1;
      if (vec_go)
         global_irq_en_d = 1'b0;
   end

   // Interrupt state and vector request
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         global_irq_en_q <= 1'b0;
         src_en_q        <= 7'h00;
         src_flag_q      <= 7'h00;
         tmr_flag_q      <= 4'h0;
         tmr_en_q        <= 4'h0;
         tick_flag_q     <= 2'h0;
         tick_en_q       <= 2'h0;
         tbase_ctrl_q    <= `ITB_TBASE_RESET;
         vec_req_q       <= 1'b0;
         vec_id_q        <= 3'h0;
         wake_q          <= 1'b0;
      end
      else
      begin
         global_irq_en_q <= global_irq_en_d;
         src_flag_q      <= src_flag_d;
         tmr_flag_q      <= tmr_flag_d;
         tick_flag_q     <= tick_flag_d;
         if (wr_en & wstrb_q[0])
            src_en_q <= wdata_q[6:0];
         if (wr_tmr & wstrb_q[1])
            tmr_en_q <= wdata_q[`ITB_EN_LSB+3:`ITB_EN_LSB];
         if (wr_tick & wstrb_q[1])
            tick_en_q <= wdata_q[`ITB_EN_LSB+1:`ITB_EN_LSB];
         if (wr_tbase & wstrb_q[0])
            tbase_ctrl_q <= wdata_q[7:0] & `ITB_TBASE_MASK;
         // Only the return address is pushed by the core on acceptance
         vec_req_q <= global_irq_en_d & ~stack_full & (|(pending & ~svc_clr));
         vec_id_q  <= prio_id(pending & ~svc_clr);
         // Any rising flag wakes, enables ignored; a preset flag cannot rise
         wake_q <= (|(src_flag_d & ~src_flag_q)) | (|(tmr_flag_d & ~tmr_flag_q)) |
                   (|(tick_flag_d & ~tick_flag_q));
      end
   end

   // Read mux; unmapped addresses answer zero with an error
   always @*
   begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      case (s_axi_araddr)
         `ITB_ADDR_CTRL:     rd_word = {31'h0, global_irq_en_q};
         `ITB_ADDR_IRQ_EN:   rd_word = {25'h0, src_en_q};
         `ITB_ADDR_IRQ_FLAG: rd_word = {25'h0, src_flag_q};
         `ITB_ADDR_TMR:      rd_word = {20'h0, tmr_en_q, 4'h0, tmr_flag_q};
         `ITB_ADDR_TICK:     rd_word = {22'h0, tick_en_q, 6'h0, tick_flag_q};
         `ITB_ADDR_TBASE:    rd_word = {24'h0, tbase_ctrl_q};
         `ITB_ADDR_STAT:     rd_word = {25'h0, vec_id_q, 2'h0, vec_req_q, stack_full};
         default:            rd_hit  = 1'b0;
      endcase
   end

   // Write channels: address and data taken in either order
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         awaddr_q      <= 8'h00;
         wdata_q       <= 32'h0000_0000;
         wstrb_q       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `ITB_RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= ~aw_have_q & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
         s_axi_wready  <= ~w_have_q & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_have_q     <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_have_q     <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write)
         begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_ctrl | wr_en | wr_flag | wr_tmr | wr_tick | wr_tbase |
                             (awaddr_q == `ITB_ADDR_STAT)) ? `ITB_RESP_OKAY : `ITB_RESP_SLVERR;
         end
         else if (s_axi_bvalid & s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel: one read in flight, data registered
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `ITB_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
         if (s_axi_arvalid & s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? `ITB_RESP_OKAY : `ITB_RESP_SLVERR;
         end
         else if (s_axi_rvalid & s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// File: include/itb_regs.vh
`ifndef ITB_REGS_VH
`define ITB_REGS_VH

// Register byte addresses
`define ITB_ADDR_CTRL      8'h00
`define ITB_ADDR_IRQ_EN    8'h04
`define ITB_ADDR_IRQ_FLAG  8'h08
`define ITB_ADDR_TMR       8'h0C
`define ITB_ADDR_TICK      8'h10
`define ITB_ADDR_TBASE     8'h14
`define ITB_ADDR_STAT      8'h18

// AXI responses
`define ITB_RESP_OKAY      2'h0
`define ITB_RESP_SLVERR    2'h2

// Reset values and write masks
`define ITB_TBASE_RESET    8'h37
`define ITB_TBASE_MASK     8'hF7

// Control and group bit positions
`define ITB_CTRL_GIE       0
`define ITB_SRC_IR         0
`define ITB_SRC_CONV       1
`define ITB_SRC_LOWV       2
`define ITB_SRC_NVW        3
`define ITB_SRC_GRP0       4
`define ITB_SRC_GRP1       5
`define ITB_SRC_GRP4       6
`define ITB_NSRC           7
`define ITB_EN_LSB         8

// Time base control fields
`define ITB_TBASE_ON       7
`define ITB_TBASE_CK       6
`define ITB_TBASE_P1_HI    5
`define ITB_TBASE_P1_LO    4
`define ITB_TBASE_P0_HI    2
`define ITB_TBASE_P0_LO    0
`define ITB_TB0_BASE       4'h8
`define ITB_TB1_BASE       4'hC
`define ITB_SYS_DIV_LAST   2'h3

// Status fields
`define ITB_STAT_SFULL     0
`define ITB_STAT_REQ       1
`define ITB_STAT_ID_LO     4

`endif

// File: hdl/itb_sync_rise.v
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser followed by a rising-edge detector
module itb_sync_rise
(
   input  wire aclk,
   input  wire aresetn,
   input  wire pin_in,
   output reg  rise_q
);

   reg meta_q;
   reg sync_q;
   reg last_q;

   // Edge detect looks only at the second stage, never the first
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
         rise_q <= 1'b0;
      end
      else
      begin
         meta_q <= pin_in;
         sync_q <= meta_q;
         last_q <= sync_q;
         rise_q <= sync_q & ~last_q;
      end
   end

endmodule
`default_nettype wire

// File: hdl/itb_tick_gen.v
`timescale 1ns/100ps
`default_nettype none
`include "itb_regs.vh"

// Two-channel time base: shared prescaled counter, two overflow taps
module itb_tick_gen
(
   input  wire       aclk,
   input  wire       aresetn,
   input  wire       sub_rise,
   input  wire [7:0] tbase_ctrl,
   output reg        tick0_q,
   output reg        tick1_q
);

   reg  [1:0]  div_q;
   reg  [14:0] cnt_q;
   wire        tick_clock;
   wire [3:0]  n0;
   wire [3:0]  n1;

   // Mask of the low n bits of the counter
   function [14:0] low_mask;
      input [3:0] n;
      begin
         low_mask = 15'h7FFF >> (4'hF - n);
      end
   endfunction

   // Channel period in bits: base plus select code
   assign n0 = `ITB_TB0_BASE + {1'b0, tbase_ctrl[`ITB_TBASE_P0_HI:`ITB_TBASE_P0_LO]};
   assign n1 = `ITB_TB1_BASE + {2'h0, tbase_ctrl[`ITB_TBASE_P1_HI:`ITB_TBASE_P1_LO]};

   // Sub clock edge or system clock over four
   assign tick_clock = tbase_ctrl[`ITB_TBASE_CK] ? (div_q == `ITB_SYS_DIV_LAST) : sub_rise;

   // One counter serves both channels, so a period change takes effect mid-count
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         div_q   <= 2'h0;
         cnt_q   <= 15'h0000;
         tick0_q <= 1'b0;
         tick1_q <= 1'b0;
      end
      else
      begin
         div_q   <= div_q + 2'h1;
         tick0_q <= 1'b0;
         tick1_q <= 1'b0;
         if (!tbase_ctrl[`ITB_TBASE_ON])
         begin
            cnt_q <= 15'h0000;
         end
         else if (tick_clock)
         begin
            cnt_q   <= cnt_q + 15'h0001;
            tick0_q <= (cnt_q & low_mask(n0)) == low_mask(n0);
            tick1_q <= (cnt_q & low_mask(n1)) == low_mask(n1);
         end
      end
   end

endmodule
`default_nettype wire

// File: dv/itb_core_model.sv
`timescale 1ns/100ps
`default_nettype none

// Core side of the vector link: accepts a vector after a short random wait,
// runs a brief routine, then returns with or without re-enabling
module itb_core_model
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       vec_req_q,
   input  wire logic [2:0] vec_id_q,
   input  wire logic       hold_full,
   input  wire logic       use_irq_return_instr,
   output logic            vec_ack,
   output logic            irq_return_instr,
   output logic            stack_full,
   output logic [2:0]      last_id,
   output int              acks
);
   int seed = 92;
   int wt = 0;
   int isr = 0;

   // One level left: the routine makes no calls, so its entry fills the stack
   assign stack_full = hold_full | (isr > 0);

   // Acknowledge, push, run the routine, return
   always @(posedge aclk)
   begin
      vec_ack <= 1'b0;
      irq_return_instr <= 1'b0;
      if (!aresetn)
      begin
         isr <= 0;
         wt <= 0;
         acks <= 0;
      end
      else if (vec_ack && vec_req_q)
      begin
         last_id <= vec_id_q;
         acks <= acks + 1;
         isr <= 6;
      end
      else if (isr > 0)
      begin
         isr <= isr - 1;
         // Plain return sends nothing, so global enable stays clear
         irq_return_instr <= (isr == 1) && use_irq_return_instr;
      end
      else if (vec_req_q)
      begin
         if (wt == 0)
            vec_ack <= 1'b1;
         wt <= (wt == 0) ? {$random(seed)} % 4 : wt - 1;
      end
   end
endmodule

`default_nettype wire

// File: dv/itb_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "itb_regs.vh"

// Bus and vector-link timing seen at the top ports
module itb_checker
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        stack_full,
   input wire logic        vec_ack,
   input wire logic        vec_req_q,
   input wire logic [2:0]  vec_id_q
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Core takes the pending vector
   sequence svc_s;
      vec_req_q && vec_ack;
   endsequence
   sequence rd_take_s;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence wr_take_s;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence

   full_block_a: assert property (stack_full |=> !vec_req_q)
      else $error("vector raised with stack full");
   // Global enable is cleared by service, so the request stays down
   svc_drop_a: assert property (svc_s |=> !vec_req_q [*2])
      else $error("request not dropped after service");
   id_range_a: assert property (vec_req_q |-> vec_id_q != 3'h7)
      else $error("vector id out of range");
   rd_answer_a: assert property (rd_take_s |=> s_axi_rvalid)
      else $error("read answer late");
   // The master always waits with rready high, so check the retire step instead
   rd_hold_a: assert property (s_axi_rvalid && s_axi_rready
      |=> !s_axi_rvalid && !s_axi_arready)
      else $error("read answer not retired");
   wr_answer_a: assert property (wr_take_s |-> ##[1:3] s_axi_bvalid)
      else $error("write answer late");
   wr_hold_a: assert property (s_axi_bvalid && s_axi_bready
      |=> !s_axi_bvalid && !s_axi_awready && !s_axi_wready)
      else $error("write answer not retired");
   wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1B
      |=> s_axi_rresp == `ITB_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
endmodule

bind itb_top itb_checker u_chk
(
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stack_full, .vec_ack,
   .vec_req_q, .vec_id_q
);

`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "itb_regs.vh"

// Self-checking bench: integer register model, core model on the vector link
module tb_top;
   logic        aclk, aresetn = 1'b0, sub = 1'b0, irs = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, ev = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, hold_full = 1'b0, use_irq_return_instr = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rrsp, wresp;
   logic        vec_req_q, wake_q, vec_ack, irq_return_instr, stack_full, wk;
   logic [2:0]  vec_id_q, last_id;
   int          acks, ex = 0, cyc = 0, seed = 92, mismatches = 0, checks_done = 0, t0;
   int          m[7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h37, 32'h0};
   int          wm[7] = '{32'h1, 32'h7F, 32'h7F, 32'hF0F, 32'h303, 32'hF7, 32'h0};

   itb_top dut
   (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ir_sense_active(irs),
      .ir_detect(ev[0]), .conv_done(ev[1]), .low_supply(ev[2]), .nv_write_end(ev[3]),
      .tmr_match(ev[7:4]), .sub_clk_pin(sub), .stack_full, .vec_ack,
      .irq_return_instr, .vec_req_q, .vec_id_q, .wake_q
   );

   itb_core_model core
   (
      .aclk, .aresetn, .vec_req_q, .vec_id_q, .hold_full, .use_irq_return_instr, .vec_ack,
      .irq_return_instr, .stack_full, .last_id, .acks
   );

   // 250 MHz system clock
   initial
   begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   // Cycle count, and a free-running sub oscillator of sixteen cycles
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc % 8 == 0)
         sub <= ~sub;
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      wresp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rdat = s_axi_rdata;
      rrsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // Register access by index, keeping the integer model in step
   task automatic wrm(input int i, input logic [31:0] d);
      wr(8'(i << 2), d);
      m[i] = d & wm[i];
   endtask

   task automatic rc(input int i, input logic [31:0] e);
      rd(8'(i << 2));
      cmp(rdat, e);
   endtask

   // One-cycle event; wake is sampled after the flag has landed
   task automatic pulse(input int k);
      @(posedge aclk);
      ev <= 8'h01 << k;
      @(posedge aclk);
      ev <= 8'h00;
      @(posedge aclk);
      wk = wake_q;
   endtask

   task automatic wait_ack(input int k);
      for (int j = 0; j < 300 && acks < k; j++)
         @(posedge aclk);
      cmp(acks, k);
   endtask

   task automatic wait_to(input int t);
      while (cyc < t)
         @(posedge aclk);
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Cut a hang: the slow time base channel dominates the run
   initial
   begin
      #200000;
      mismatches++;
      close_out();
   end

   initial
   begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 6; i++)
         rc(i, m[i]);
      rd(8'h1C);
      cmp(rrsp, `ITB_RESP_SLVERR);
      wr(8'h1C, 32'hFFFFFFFF);
      cmp(wresp, `ITB_RESP_SLVERR);
      // Random read-back, then cleared so group flags settle first
      for (int i = 1; i < 6; i++)
      begin
         wrm(i, $random(seed));
         rc(i, m[i]);
         // Upper lane only: member enables clear, member flags untouched
         if (i == 3)
         begin
            s_axi_wstrb <= 4'h2;
            wr(8'h0C, 32'h0);
            s_axi_wstrb <= 4'hF;
            cmp(wresp, `ITB_RESP_OKAY);
            m[3] = m[3] & 32'hF;
            rc(3, m[3]);
         end
      end
      for (int i = 5; i > 0; i--)
         wrm(i, 32'h0);
      $display("test end: registers");
      pulse(0);
      cmp(wk, 1'b0);
      irs <= 1'b1;
      for (int s = 0; s < 4; s++)
      begin
         pulse(s);
         cmp(wk, 1'b1);
         rc(2, 1 << s);
         wrm(1, 1 << s);
         cmp(vec_req_q, 1'b0);
         wrm(0, 32'h1);
         ex++;
         wait_ack(ex);
         cmp(last_id, s);
         repeat (10) @(posedge aclk);
         rc(2, 32'h0);
         rc(0, 32'h0);
      end
      $display("test end: single sources");
      hold_full <= 1'b1;
      pulse(1);
      wrm(1, 32'h2);
      wrm(0, 32'h1);
      repeat (20) @(posedge aclk);
      rd(8'h18);
      cmp(rdat & 32'h3, 32'h1);
      hold_full <= 1'b0;
      ex++;
      wait_ack(ex);
      cmp(last_id, 3'h1);
      wrm(2, 32'h2);
      pulse(1);
      cmp(wk, 1'b0);
      wrm(1, 32'h0);
      rc(2, 32'h2);
      wrm(2, 32'h0);
      $display("test end: stack and wake");
      for (int j = 0; j < 4; j++)
      begin
         wrm(3, 32'h100 << j);
         pulse(4 + j);
         cmp(wk, 1'b1);
         rc(3, 32'h101 << j);
         rc(2, 32'h10 << (j / 2));
         wrm(1, 32'h10 << (j / 2));
         wrm(0, 32'h1);
         ex++;
         wait_ack(ex);
         cmp(last_id, 4 + j / 2);
         rc(2, 32'h0);
         rc(3, 32'h101 << j);
         wrm(3, 32'h0);
      end
      $display("test end: groups");
      use_irq_return_instr <= 1'b1;
      wrm(2, 32'hA);
      wrm(1, 32'hA);
      wrm(0, 32'h1);
      wait_ack(ex + 1);
      cmp(last_id, 3'h1);
      wait_ack(ex + 2);
      cmp(last_id, 3'h3);
      ex += 2;
      repeat (12) @(posedge aclk);
      rc(0, 32'h1);
      use_irq_return_instr <= 1'b0;
      wrm(0, 32'h0);
      $display("test end: priority");
      wrm(1, 32'h40);
      wrm(4, 32'h100);
      wrm(0, 32'h1);
      wrm(5, 32'hC0);
      t0 = cyc;
      wait_to(t0 + 990);
      rc(4, 32'h100);
      wait_to(t0 + 1080);
      rc(4, 32'h101);
      ex++;
      cmp(acks, ex);
      cmp(last_id, 3'h6);
      wait_to(t0 + 16330);
      rc(4, 32'h101);
      wait_to(t0 + 16460);
      rc(4, 32'h103);
      // Off first, so the shared counter restarts from zero
      wrm(5, 32'h0);
      wrm(4, 32'h0);
      wrm(5, 32'h80);
      t0 = cyc;
      wait_to(t0 + 3950);
      rc(4, 32'h0);
      wait_to(t0 + 4200);
      rc(4, 32'h1);
      // Channel zero at the next period code, system clock over four
      wrm(5, 32'h0);
      wrm(4, 32'h0);
      wrm(5, 32'hC1);
      t0 = cyc;
      wait_to(t0 + 1990);
      rc(4, 32'h0);
      wait_to(t0 + 2130);
      rc(4, 32'h1);
      wrm(5, 32'h40);
      wrm(4, 32'h0);
      t0 = cyc;
      wait_to(t0 + 1200);
      rc(4, 32'h0);
      $display("test end: time base");
      close_out();
   end
endmodule

`default_nettype wire
